//--- core/tcc_pkg.sv
package tcc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned TCC_AW = 3;
  localparam int unsigned TCC_DW = 8;
  localparam int unsigned TCC_PRE_W_DEF = 10;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [TCC_AW-1:0] TCC_OFF_COUNT = 3'h0;
  localparam logic [TCC_AW-1:0] TCC_OFF_CMP_A = 3'h1;
  localparam logic [TCC_AW-1:0] TCC_OFF_CMP_B = 3'h2;
  localparam logic [TCC_AW-1:0] TCC_OFF_CTL_A = 3'h3;
  localparam logic [TCC_AW-1:0] TCC_OFF_CTL_B = 3'h4;
  localparam logic [TCC_AW-1:0] TCC_OFF_FLAG  = 3'h5;
  localparam logic [TCC_AW-1:0] TCC_OFF_MASK  = 3'h6;
  localparam logic [TCC_AW-1:0] TCC_OFF_PWR   = 3'h7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned TCC_WGM0_POS = 0;
  localparam int unsigned TCC_WGM1_POS = 1;
  localparam int unsigned TCC_CS_LSB   = 0;
  localparam int unsigned TCC_WGM2_POS = 3;
  localparam int unsigned TCC_OV_POS   = 0;
  localparam int unsigned TCC_MA_POS   = 1;
  localparam int unsigned TCC_MB_POS   = 2;
  localparam int unsigned TCC_PWR_POS  = 0;

  // ****************************************
  // reset values and count limits
  // ****************************************
  localparam logic [TCC_DW-1:0] TCC_RST_BYTE   = 8'h00;
  localparam logic [2:0]        TCC_RST_FLAGS  = 3'h0;
  localparam logic              TCC_RST_BIT    = 1'h0;
  localparam logic              TCC_RST_BOTTOM = 1'h1;
  localparam logic [TCC_DW-1:0] TCC_MAX        = 8'hff;
  localparam logic [TCC_DW-1:0] TCC_BOTTOM     = 8'h00;

  // ****************************************
  // tick source select codes and prescale taps
  // ****************************************
  localparam logic [2:0] TCC_CS_STOP     = 3'h0;
  localparam logic [2:0] TCC_CS_DIV1     = 3'h1;
  localparam logic [2:0] TCC_CS_DIV8     = 3'h2;
  localparam logic [2:0] TCC_CS_DIV64    = 3'h3;
  localparam logic [2:0] TCC_CS_DIV256   = 3'h4;
  localparam logic [2:0] TCC_CS_DIV1024  = 3'h5;
  localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;
  localparam int unsigned TCC_TAP_DIV8    = 3;
  localparam int unsigned TCC_TAP_DIV64   = 6;
  localparam int unsigned TCC_TAP_DIV256  = 8;
  localparam int unsigned TCC_TAP_DIV1024 = 10;

  // ****************************************
  // waveform modes
  // ****************************************
  localparam logic [2:0] TCC_WGM_NORMAL   = 3'h0;
  localparam logic [2:0] TCC_WGM_PC_MAX   = 3'h1;
  localparam logic [2:0] TCC_WGM_CTC      = 3'h2;
  localparam logic [2:0] TCC_WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] TCC_WGM_PC_CMP   = 3'h5;
  localparam logic [2:0] TCC_WGM_FAST_CMP = 3'h7;

  typedef enum logic {TCC_UP, TCC_DOWN} tcc_dir_e;

  typedef struct packed {
    logic [TCC_AW-1:0] addr;
    logic [TCC_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } tcc_bus_s;

endpackage

//--- core/tcc_timer_core.sv
`timescale 1ns/1ns
`default_nettype none

module tcc_timer_core
  import tcc_pkg::*;
#(
  parameter int unsigned PRE_W = tcc_pkg::TCC_PRE_W_DEF
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      nrst_in,
  input  wire tcc_pkg::tcc_bus_s         bus_in,
  input  wire logic [2:0]                flag_ack_in,
  input  wire logic                      external_count_pin_in,
  output logic [tcc_pkg::TCC_DW-1:0]     rdata_out,
  output logic [2:0]                     irq_req_out,
  output logic                           top_out,
  output logic                           bottom_out
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (PRE_W < TCC_TAP_DIV1024) begin : g_pre_chk
    $error("prescaler too narrow for the divide-by-1024 tap");
  end

  // ****************************************
  // registers
  // ****************************************
  logic [TCC_DW-1:0] count_value_r;
  logic [TCC_DW-1:0] count_value_nxt;
  logic [TCC_DW-1:0] compare_value_a_r;
  logic [TCC_DW-1:0] compare_value_b_r;
  logic [1:0]        wave_mode_lo_r;
  logic              wave_mode_bit2_r;
  logic [2:0]        tick_source_select_r;
  logic [2:0]        timer_irq_flag_reg_r;
  logic [2:0]        timer_irq_flag_reg_nxt;
  logic [2:0]        timer_irq_mask_reg_r;
  logic              timer_power_off_bit_r;
  tcc_dir_e          dir_r;
  tcc_dir_e          dir_nxt;
  logic              block_r;
  logic [PRE_W-1:0]  pre_r;
  logic              ext_s1_r;
  logic              ext_s2_r;
  logic              ext_prev_r;
  logic [TCC_DW-1:0] rdata_r;
  logic [2:0]        irq_r;
  logic              top_r;
  logic              bottom_r;

  // ****************************************
  // bus decode
  // ****************************************
  logic wr_count;
  logic wr_flag;

  assign wr_count = bus_in.wr && (bus_in.addr == TCC_OFF_COUNT);
  assign wr_flag  = bus_in.wr && (bus_in.addr == TCC_OFF_FLAG);

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      compare_value_a_r     <= TCC_RST_BYTE;
      compare_value_b_r     <= TCC_RST_BYTE;
      wave_mode_lo_r        <= TCC_RST_BYTE[1:0];
      wave_mode_bit2_r      <= TCC_RST_BIT;
      tick_source_select_r  <= TCC_RST_BYTE[2:0];
      timer_irq_mask_reg_r  <= TCC_RST_FLAGS;
      timer_power_off_bit_r <= TCC_RST_BIT;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        TCC_OFF_CMP_A: compare_value_a_r <= bus_in.wdata;
        TCC_OFF_CMP_B: compare_value_b_r <= bus_in.wdata;
        TCC_OFF_CTL_A: begin
          wave_mode_lo_r <= {bus_in.wdata[TCC_WGM1_POS], bus_in.wdata[TCC_WGM0_POS]};
        end
        TCC_OFF_CTL_B: begin
          tick_source_select_r <= bus_in.wdata[TCC_CS_LSB +: 3];
          wave_mode_bit2_r     <= bus_in.wdata[TCC_WGM2_POS];
        end
        TCC_OFF_MASK:  timer_irq_mask_reg_r <= bus_in.wdata[2:0];
        TCC_OFF_PWR:   timer_power_off_bit_r <= bus_in.wdata[TCC_PWR_POS];
        default: ;
      endcase
    end
  end

  // ****************************************
  // tick source
  // ****************************************
  // only the second stage feeds the edge detector
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      ext_s1_r   <= TCC_RST_BIT;
      ext_s2_r   <= TCC_RST_BIT;
      ext_prev_r <= TCC_RST_BIT;
    end else begin
      ext_s1_r   <= external_count_pin_in;
      ext_s2_r   <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  // prescaler free runs; it halts with the block powered off
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pre_r <= '0;
    end else if (!timer_power_off_bit_r) begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end

  logic timer_tick;
  logic src_tick;

  always_comb begin
    src_tick = 1'b0;
    unique case (tick_source_select_r)
      TCC_CS_STOP:     src_tick = 1'b0;
      TCC_CS_DIV1:     src_tick = 1'b1;
      TCC_CS_DIV8:     src_tick = &pre_r[TCC_TAP_DIV8-1:0];
      TCC_CS_DIV64:    src_tick = &pre_r[TCC_TAP_DIV64-1:0];
      TCC_CS_DIV256:   src_tick = &pre_r[TCC_TAP_DIV256-1:0];
      TCC_CS_DIV1024:  src_tick = &pre_r[TCC_TAP_DIV1024-1:0];
      TCC_CS_EXT_FALL: src_tick = ext_prev_r && !ext_s2_r;
      TCC_CS_EXT_RISE: src_tick = ext_s2_r && !ext_prev_r;
    endcase
  end

  assign timer_tick = src_tick && !timer_power_off_bit_r;

  // ****************************************
  // mode decode
  // ****************************************
  logic [2:0]        wave_mode;
  logic [TCC_DW-1:0] top_val;
  logic              updown;
  logic              clr_at_top;
  logic              fast_pwm;
  logic              at_top;
  logic              at_bottom;

  assign wave_mode  = {wave_mode_bit2_r, wave_mode_lo_r};
  assign top_val    = (wave_mode == TCC_WGM_CTC || wave_mode == TCC_WGM_PC_CMP ||
                       wave_mode == TCC_WGM_FAST_CMP) ? compare_value_a_r : TCC_MAX;
  assign updown     = (wave_mode == TCC_WGM_PC_MAX) || (wave_mode == TCC_WGM_PC_CMP);
  assign fast_pwm   = (wave_mode == TCC_WGM_FAST_MAX) || (wave_mode == TCC_WGM_FAST_CMP);
  assign clr_at_top = fast_pwm || (wave_mode == TCC_WGM_CTC);
  assign at_top     = (count_value_r == top_val);
  assign at_bottom  = (count_value_r == TCC_BOTTOM);

  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    count_value_nxt = count_value_r;
    dir_nxt         = dir_r;
    if (wr_count) begin
      count_value_nxt = bus_in.wdata;
    end else if (timer_tick) begin
      if (updown) begin
        if (dir_r == TCC_UP && at_top) begin
          dir_nxt         = TCC_DOWN;
          count_value_nxt = count_value_r - 8'h01;
        end else if (dir_r == TCC_DOWN && at_bottom) begin
          dir_nxt         = TCC_UP;
          count_value_nxt = count_value_r + 8'h01;
        end else if (dir_r == TCC_DOWN) begin
          count_value_nxt = count_value_r - 8'h01;
        end else begin
          count_value_nxt = count_value_r + 8'h01;
        end
      end else if (clr_at_top && at_top) begin
        count_value_nxt = TCC_BOTTOM;
      end else begin
        dir_nxt         = TCC_UP;
        count_value_nxt = count_value_r + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      count_value_r <= TCC_RST_BYTE;
      dir_r         <= TCC_UP;
    end else begin
      count_value_r <= count_value_nxt;
      dir_r         <= dir_nxt;
    end
  end

  // indications follow the count with no lag; top tracks top_val (compare a, or max in the max-top modes) as it stood
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      top_r    <= TCC_RST_BIT;
      bottom_r <= TCC_RST_BOTTOM;
    end else begin
      top_r    <= (count_value_nxt == top_val);
      bottom_r <= (count_value_nxt == TCC_BOTTOM);
    end
  end

  // ****************************************
  // compare and flags
  // ****************************************
  logic match_a;
  logic match_b;
  logic ov_evt;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  assign match_a = (count_value_r == compare_value_a_r);
  assign match_b = (count_value_r == compare_value_b_r);

  // a same-cycle count write overrides the tick, so no overflow then
  assign ov_evt = timer_tick && !wr_count &&
                  (fast_pwm ? at_top : (updown ? at_bottom : count_value_r == TCC_MAX));

  always_comb begin
    flag_set              = 3'h0;
    flag_set[TCC_OV_POS]  = ov_evt;
    flag_set[TCC_MA_POS]  = timer_tick && !block_r && match_a;
    flag_set[TCC_MB_POS]  = timer_tick && !block_r && match_b;
    flag_clr              = flag_ack_in | (wr_flag ? bus_in.wdata[2:0] : 3'h0);
    timer_irq_flag_reg_nxt = (timer_irq_flag_reg_r & ~flag_clr) | flag_set; // set beats clear
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      timer_irq_flag_reg_r <= TCC_RST_FLAGS;
    end else begin
      timer_irq_flag_reg_r <= timer_irq_flag_reg_nxt;
    end
  end

  // block lasts until a tick consumes it, even if the timer is stopped
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      block_r <= TCC_RST_BIT;
    end else if (wr_count) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      irq_r <= TCC_RST_FLAGS;
    end else begin
      irq_r <= timer_irq_flag_reg_r & timer_irq_mask_reg_r;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rdata_r <= TCC_RST_BYTE;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        TCC_OFF_COUNT: rdata_r <= count_value_r;
        TCC_OFF_CMP_A: rdata_r <= compare_value_a_r;
        TCC_OFF_CMP_B: rdata_r <= compare_value_b_r;
        TCC_OFF_CTL_A: rdata_r <= {6'h00, wave_mode_lo_r};
        TCC_OFF_CTL_B: rdata_r <= {4'h0, wave_mode_bit2_r, tick_source_select_r};
        TCC_OFF_FLAG:  rdata_r <= {5'h00, timer_irq_flag_reg_r};
        TCC_OFF_MASK:  rdata_r <= {5'h00, timer_irq_mask_reg_r};
        TCC_OFF_PWR:   rdata_r <= {7'h00, timer_power_off_bit_r};
        default:       rdata_r <= TCC_RST_BYTE;
      endcase
    end else begin
      rdata_r <= TCC_RST_BYTE;
    end
  end

  assign rdata_out   = rdata_r;
  assign irq_req_out = irq_r;
  assign top_out     = top_r;
  assign bottom_out  = bottom_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_quiet_tick;
    timer_tick && !wr_count;
  endsequence

  sequence s_cnt_write;
    wr_count;
  endsequence

  a_stop_holds_count: assert property (
    (tick_source_select_r == TCC_CS_STOP && !wr_count) |=> $stable(count_value_r))
    else $error("count moved with tick source stopped");

  a_write_wins_count: assert property (
    s_cnt_write |=> count_value_r == $past(bus_in.wdata))
    else $error("count write did not win");

  a_normal_step_one: assert property (
    (s_quiet_tick ##0 wave_mode == TCC_WGM_NORMAL) |=>
      count_value_r == 8'($past(count_value_r) + 8'h01))
    else $error("normal mode step not one");

  a_ctc_clear_top: assert property (
    (s_quiet_tick ##0 wave_mode == TCC_WGM_CTC && at_top) |=> count_value_r == TCC_BOTTOM)
    else $error("ctc did not clear at top");

  a_bottom_tracks: assert property (
    bottom_out == (count_value_r == TCC_BOTTOM))
    else $error("bottom indication wrong");

  a_normal_overflow: assert property (
    (s_quiet_tick ##0 wave_mode == TCC_WGM_NORMAL && count_value_r == TCC_MAX) |=>
      timer_irq_flag_reg_r[TCC_OV_POS] ##1
      irq_req_out[TCC_OV_POS] == $past(timer_irq_mask_reg_r[TCC_OV_POS]))
    else $error("overflow flag or request missing");

  a_match_sets_flag: assert property (
    (timer_tick && !block_r && match_a) |=> timer_irq_flag_reg_r[TCC_MA_POS])
    else $error("match a did not set its flag");

  a_write_blocks_match: assert property (
    (s_cnt_write ##1 (!wr_count && timer_tick && !timer_irq_flag_reg_r[TCC_MB_POS])) |=>
      !timer_irq_flag_reg_r[TCC_MB_POS])
    else $error("match not blocked after count write");

  a_power_off_hold: assert property (
    (timer_power_off_bit_r && !wr_count) [*2] |=> $stable(count_value_r))
    else $error("count moved while powered off");

endmodule

`default_nettype wire

//--- sim/tcc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_cpu_model (
  input  wire logic                     core_clk_in,
  input  wire logic [tcc_pkg::TCC_DW-1:0] rdata_in,
  input  wire logic                     top_in,
  input  wire logic                     bottom_in,
  output var tcc_pkg::tcc_bus_s         bus_out,
  output var logic [2:0]                ack_out
);
  import tcc_pkg::*;
  logic [TCC_DW-1:0] buf_r [0:63];
  logic              top_seen;
  logic              bottom_seen;
  initial begin
    bus_out = '0;
    ack_out = 3'h0;
  end
  // ****************************************
  // register bus cycles
  // ****************************************
  task automatic write_reg(input logic [TCC_AW-1:0] a, input logic [TCC_DW-1:0] d);
    @(posedge core_clk_in);
    bus_out.addr <= a;
    bus_out.wdata <= d;
    bus_out.wr <= 1'h1;
    @(posedge core_clk_in);
    bus_out.wr <= 1'h0;
    bus_out.wdata <= ~d;
  endtask
  // back to back reads, one byte a cycle
  task automatic read_burst(input logic [TCC_AW-1:0] a, input int n);
    top_seen = 1'h0;
    bottom_seen = 1'h0;
    @(posedge core_clk_in);
    bus_out.addr <= a;
    bus_out.rd <= 1'h1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_in);
      if (i == n - 1) bus_out.rd <= 1'h0;
      #1;
      buf_r[i] = rdata_in;
      top_seen = top_seen | top_in;
      bottom_seen = bottom_seen | bottom_in;
    end
  endtask
  // ****************************************
  // interrupt entry, answered late on purpose
  // ****************************************
  task automatic ack_irq(input int idx, input int delay);
    repeat (delay) @(posedge core_clk_in);
    ack_out[idx] <= 1'h1;
    @(posedge core_clk_in);
    ack_out[idx] <= 1'h0;
  endtask
endmodule
`default_nettype wire

//--- sim/tcc_timer_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_core_bench;
  import tcc_pkg::*;
  logic              core_clk_in;
  logic              nrst_in;
  logic              ext_pin;
  tcc_bus_s          bus;
  logic [2:0]        ack;
  logic [TCC_DW-1:0] rdata;
  logic [2:0]        irq;
  logic              top;
  logic              bottom;
  int                n_fail;
  int                checks_done;

  tcc_timer_core #(.PRE_W(TCC_PRE_W_DEF)) uut (
    .core_clk_in           (core_clk_in),
    .nrst_in               (nrst_in),
    .bus_in                (bus),
    .flag_ack_in           (ack),
    .external_count_pin_in (ext_pin),
    .rdata_out             (rdata),
    .irq_req_out           (irq),
    .top_out               (top),
    .bottom_out            (bottom)
  );
  tcc_cpu_model cpu (
    .core_clk_in (core_clk_in),
    .rdata_in    (rdata),
    .top_in      (top),
    .bottom_in   (bottom),
    .bus_out     (bus),
    .ack_out     (ack)
  );

  initial begin
    core_clk_in = 1'h0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cpu.write_reg(a, d);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    cpu.read_burst(a, 1);
    v = cpu.buf_r[0];
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] v;
    check("bottom", bottom, 8'h01);
    check("top", top, 8'h00);
    check("irq", irq, 8'h00);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], v);
      check("reset reg", v, 8'h00);
    end
    wr(TCC_OFF_CTL_A, 8'hff);
    rd(TCC_OFF_CTL_A, v);
    check("ctl a bits", v, 8'h03);
    wr(TCC_OFF_CTL_A, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_stop();
    logic [7:0] v;
    wr(TCC_OFF_COUNT, 8'h10);
    cyc(20);
    rd(TCC_OFF_COUNT, v);
    check("stopped", v, 8'h10);
    wr(TCC_OFF_PWR, 8'h01);
    wr(TCC_OFF_CTL_B, {5'h00, TCC_CS_DIV1});
    cyc(20);
    rd(TCC_OFF_COUNT, v);
    check("power off", v, 8'h10);
    wr(TCC_OFF_CTL_B, 8'h00);
    wr(TCC_OFF_PWR, 8'h00);
    $display("test stop done");
  endtask
  task automatic t_step();
    logic [7:0] v;
    wr(TCC_OFF_COUNT, 8'h20);
    wr(TCC_OFF_CTL_B, {5'h00, TCC_CS_DIV1});
    cpu.read_burst(TCC_OFF_COUNT, 2);
    check("step", cpu.buf_r[1] - cpu.buf_r[0], 8'h01);
    wr(TCC_OFF_COUNT, 8'h77);
    rd(TCC_OFF_COUNT, v);
    check("write wins", v, 8'h78);
    wr(TCC_OFF_COUNT, 8'hfd);
    cyc(6);
    wr(TCC_OFF_CTL_B, 8'h00);
    rd(TCC_OFF_FLAG, v);
    check("overflow", v, 8'h07);
    wr(TCC_OFF_FLAG, 8'h07);
    rd(TCC_OFF_FLAG, v);
    check("flags cleared", v, 8'h00);
    $display("test step done");
  endtask
  task automatic t_flags();
    logic [7:0] v;
    wr(TCC_OFF_CMP_A, 8'h40);
    wr(TCC_OFF_CMP_B, 8'h41);
    wr(TCC_OFF_COUNT, 8'h40);
    wr(TCC_OFF_CTL_B, {5'h00, TCC_CS_DIV1});
    cyc(3);
    wr(TCC_OFF_CTL_B, 8'h00);
    rd(TCC_OFF_FLAG, v);
    check("blocked match", v, 8'h04);
    check("masked irq", irq, 8'h00);
    wr(TCC_OFF_MASK, 8'h04);
    cyc(2);
    check("irq b", irq, 8'h04);
    cpu.ack_irq(2, 3);
    cyc(2);
    check("irq acked", irq, 8'h00);
    rd(TCC_OFF_FLAG, v);
    check("flag acked", v, 8'h00);
    wr(TCC_OFF_COUNT, 8'h3e);
    wr(TCC_OFF_CTL_B, {5'h00, TCC_CS_DIV1});
    cyc(5);
    wr(TCC_OFF_CTL_B, 8'h00);
    rd(TCC_OFF_FLAG, v);
    check("both match", v, 8'h06);
    check("irq gated", irq, 8'h04);
    wr(TCC_OFF_FLAG, 8'h02);
    rd(TCC_OFF_FLAG, v);
    check("write one", v, 8'h04);
    wr(TCC_OFF_FLAG, 8'h04);
    wr(TCC_OFF_MASK, 8'h00);
    // count written onto compare b while running: next tick must not match
    wr(TCC_OFF_CTL_B, {5'h00, TCC_CS_DIV1});
    wr(TCC_OFF_COUNT, 8'h41);
    wr(TCC_OFF_CTL_B, 8'h00);
    rd(TCC_OFF_FLAG, v);
    check("running block", v, 8'h00);
    $display("test flags done");
  endtask
  task automatic t_modes();
    logic [7:0] mx;
    logic       dn;
    // fast max runs just before phase correct max so that one starts counting up, not down
    logic [2:0] md [5] = '{3'h2, 3'h7, 3'h5, 3'h3, 3'h1};
    logic [7:0] st [5] = '{8'h00, 8'h00, 8'h00, 8'hf8, 8'hf8};
    logic [7:0] xm [5] = '{8'h05, 8'h05, 8'h05, 8'hff, 8'hff};
    logic       xd [5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h1};
    logic       xb [5] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
    for (int r = 0; r < 5; r++) begin
      wr(TCC_OFF_CTL_B, 8'h00);
      wr(TCC_OFF_CTL_A, {6'h00, md[r][1:0]});
      wr(TCC_OFF_CMP_A, 8'h05);
      wr(TCC_OFF_COUNT, st[r]);
      wr(TCC_OFF_CTL_B, {4'h0, md[r][2], TCC_CS_DIV1});
      cpu.read_burst(TCC_OFF_COUNT, 40);
      mx = cpu.buf_r[0];
      dn = 1'h0;
      for (int i = 1; i < 40; i++) begin
        if (cpu.buf_r[i] > mx) mx = cpu.buf_r[i];
        if (cpu.buf_r[i] == cpu.buf_r[i-1] - 8'h01) dn = 1'h1;
      end
      check("mode top", mx, xm[r]);
      check("mode dir", dn, xd[r]);
      check("top seen", cpu.top_seen, 8'h01);
      check("bottom seen", cpu.bottom_seen, xb[r]);
    end
    wr(TCC_OFF_CTL_B, 8'h00);
    wr(TCC_OFF_CTL_A, 8'h00);
    $display("test modes done");
  endtask
  task automatic t_prescale();
    logic [7:0] v;
    logic [2:0] cs [4] = '{TCC_CS_DIV8, TCC_CS_DIV64, TCC_CS_DIV256, TCC_CS_DIV1024};
    int         sh [4] = '{3, 6, 8, 10};
    for (int k = 0; k < 4; k++) begin
      wr(TCC_OFF_COUNT, 8'h00);
      wr(TCC_OFF_CTL_B, {5'h00, cs[k]});
      cyc(10 << sh[k]);
      wr(TCC_OFF_CTL_B, 8'h00);
      rd(TCC_OFF_COUNT, v);
      // free running prescaler, so phase gives one tick of slack
      check("prescale", (v >= 8'h09 && v <= 8'h0b), 8'h01);
    end
    $display("test prescale done");
  endtask
  task automatic t_ext();
    logic [7:0] v;
    logic [2:0] src [2] = '{TCC_CS_EXT_FALL, TCC_CS_EXT_RISE};
    for (int k = 0; k < 2; k++) begin
      wr(TCC_OFF_COUNT, 8'h00);
      wr(TCC_OFF_CTL_B, {5'h00, src[k]});
      repeat (3) begin
        ext_pin <= 1'h1;
        cyc(4);
        ext_pin <= 1'h0;
        cyc(4);
      end
      cyc(4);
      wr(TCC_OFF_CTL_B, 8'h00);
      rd(TCC_OFF_COUNT, v);
      check("ext edges", v, 8'h03);
    end
    $display("test external done");
  endtask
  // ****************************************
  // main sequence and hang guard
  // ****************************************
  initial begin
    nrst_in = 1'h0;
    ext_pin = 1'h0;
    n_fail = 0;
    checks_done = 0;
    repeat (4) @(posedge core_clk_in);
    nrst_in <= 1'h1;
    t_reset();
    t_stop();
    t_step();
    t_flags();
    t_modes();
    t_prescale();
    t_ext();
    // mid-run reset must wipe every register again
    @(posedge core_clk_in);
    nrst_in <= 1'h0;
    repeat (4) @(posedge core_clk_in);
    nrst_in <= 1'h1;
    t_reset();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge core_clk_in);
    n_fail++;
    $display("timeout");
    test_done();
  end
endmodule
`default_nettype wire
